// [ptm_edge_det.sv]
// Purpose: Edge detector for one synchronous pin input
// Assumes: Input already synchronous to sys_clk
// Notes: Emits one-cycle pulses on rising and falling edges
`timescale 1ns/100ps
module ptm_edge_det
    import ptm_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Pin level and edge pulses
    input wire logic pin_level,
    output logic rise_pulse,
    output logic fall_pulse
);

    typedef struct packed
    {
        logic last_reg;
    } ptm_edge_state_type;

    ptm_edge_state_type state_reg;
    ptm_edge_state_type state_next;

    ////////////////////////////////////////////////////////////////////////
    // Remember previous level
    always_comb
    begin
        state_next.last_reg = pin_level;
    end

    // Synchronous reset to low
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    // Edge pulses
    assign rise_pulse = pin_level & ~state_reg.last_reg;
    assign fall_pulse = ~pin_level & state_reg.last_reg;

endmodule

// [ptm_pin_model.sv]
// Purpose: Far-side drivers of the trigger and capture pins
// Assumes: Pins idle low, as with a pull-down
// Notes: Pulse width in cycles sets a prompt or a slow partner
`timescale 1ns/100ps
module ptm_pin_model
(
    // Clock
    input wire logic sys_clk,
    // Pins towards the timer
    output logic external_trigger_pin,
    output logic capture_input_pin
);
    // Idle level from time zero
    initial {external_trigger_pin, capture_input_pin} = 2'b00;
    // One high pulse on the chosen pin, launched after an edge
    task automatic pulse(input logic use_trig, input int width);
        @(posedge sys_clk);
        if (use_trig)
            external_trigger_pin <= 1'b1;
        else
            capture_input_pin <= 1'b1;
        repeat (width) @(posedge sys_clk);
        external_trigger_pin <= 1'b0;
        capture_input_pin <= 1'b0;
    endtask
endmodule

// [ptm_pkg.sv]
// Purpose: Shared constants and types for the 10-bit periodic timer
// Assumes: Classic Wishbone register access, 32-bit data, byte registers
// Notes: Register offsets are byte addresses of aligned words
package ptm_pkg;

    // Register byte offsets
    localparam logic [4:0] PTM_CTRL0_OFS = 5'h00;
    localparam logic [4:0] PTM_CTRL1_OFS = 5'h04;
    localparam logic [4:0] PTM_CNT_LO_OFS = 5'h08;
    localparam logic [4:0] PTM_CNT_HI_OFS = 5'h0C;
    localparam logic [4:0] PTM_CMPA_LO_OFS = 5'h10;
    localparam logic [4:0] PTM_CMPA_HI_OFS = 5'h14;
    localparam logic [4:0] PTM_PER_LO_OFS = 5'h18;
    localparam logic [4:0] PTM_PER_HI_OFS = 5'h1C;
    localparam logic [4:0] PTM_FLAG_OFS = 5'h00;
    localparam logic [1:0] PTM_FLAG_PAGE = 2'h1;

    // Control zero field positions
    localparam int PTM_PAUSE_BIT = 7;
    localparam int PTM_ON_BIT = 3;

    // Control one field positions
    localparam int PTM_MODE_LSB = 6;
    localparam int PTM_FUNC_LSB = 4;
    localparam int PTM_OC_BIT = 3;
    localparam int PTM_POL_BIT = 2;
    localparam int PTM_CSRC_BIT = 1;
    localparam int PTM_CCLR_BIT = 0;

    // Flag register positions
    localparam int PTM_FLAG_A_BIT = 1;
    localparam int PTM_FLAG_P_BIT = 0;

    // Widths and reset values
    localparam int PTM_CNT_W = 10;
    localparam logic [9:0] PTM_CNT_MAX = 10'h3FF;
    localparam logic [7:0] PTM_BYTE_RST = 8'h00;
    localparam logic [9:0] PTM_CNT_RST = 10'h000;

    // Operating modes
    typedef enum logic [1:0]
    {
        PTM_MODE_CMP = 2'b00,
        PTM_MODE_CAP = 2'b01,
        PTM_MODE_PWM = 2'b10,
        PTM_MODE_TMR = 2'b11
    } ptm_mode_type;

    // Output function codes for compare, PWM and capture modes
    localparam logic [1:0] PTM_FN_NONE = 2'b00;
    localparam logic [1:0] PTM_FN_LOW = 2'b01;
    localparam logic [1:0] PTM_FN_HIGH = 2'b10;
    localparam logic [1:0] PTM_FN_TOG = 2'b11;
    localparam logic [1:0] PTM_FN_PWM = 2'b10;
    localparam logic [1:0] PTM_FN_PULSE = 2'b11;
    localparam logic [1:0] PTM_FN_CAP_OFF = 2'b11;

endpackage

// [ptm_timer.sv]
// Purpose: 10-bit periodic timer with compare, PWM, pulse, capture modes
// Assumes: One counter tick per sys_clk while running, classic Wishbone
// Notes: Clock source selection is not modelled; the counter runs on sys_clk
//
// Our own choices: the register offsets and register access over Wishbone.
`timescale 1ns/100ps
module ptm_timer
    import ptm_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // Pins
    input wire logic external_trigger_pin,
    input wire logic capture_input_pin,
    output logic timer_output_pin,
    output logic timer_output_oe,
    // Match flags as levels
    output logic compare_a_flag,
    output logic compare_p_flag
);

    typedef struct packed
    {
        logic [7:0] ctrl0;
        logic [7:0] ctrl1;
        logic [9:0] count;
        logic [9:0] cmp_a;
        logic [9:0] period;
        logic flag_a;
        logic flag_p;
        logic on_last;
        logic pin_raw;
        logic pin_out;
        logic pin_oe;
        logic ack;
        logic err;
        logic [31:0] rdata;
    } ptm_state_type;

    ptm_state_type state_reg;
    ptm_state_type state_next;

    logic trig_rise;
    logic trig_fall;
    logic cin_rise;
    logic cin_fall;

    ////////////////////////////////////////////////////////////////////////
    // Pin edge detectors
    ptm_edge_det trig_edge
    (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .pin_level(external_trigger_pin),
        .rise_pulse(trig_rise),
        .fall_pulse(trig_fall)
    );

    ptm_edge_det cin_edge
    (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .pin_level(capture_input_pin),
        .rise_pulse(cin_rise),
        .fall_pulse(cin_fall)
    );

    ////////////////////////////////////////////////////////////////////////
    // Decoded fields
    ptm_mode_type mode;
    logic [1:0] func;
    logic on_bit;
    logic paused;
    logic oc_bit;
    logic pol_bit;
    logic [9:0] count_inc;
    logic match_a;
    logic match_p;
    logic overflow;
    logic on_rise;
    logic cap_rise;
    logic cap_fall;
    logic cap_hit;
    logic pulse_mode;
    logic bus_req;
    logic bus_wr;
    logic [4:0] reg_ofs;
    logic flag_page;

    always_comb
    begin
        mode = ptm_mode_type'(state_reg.ctrl1[PTM_MODE_LSB +: 2]);
        func = state_reg.ctrl1[PTM_FUNC_LSB +: 2];
        on_bit = state_reg.ctrl0[PTM_ON_BIT];
        paused = state_reg.ctrl0[PTM_PAUSE_BIT];
        oc_bit = state_reg.ctrl1[PTM_OC_BIT];
        pol_bit = state_reg.ctrl1[PTM_POL_BIT];
        count_inc = state_reg.count + 10'h001;
        // Comparators look at the count reached this tick
        match_a = (count_inc == state_reg.cmp_a);
        match_p = (count_inc[9:0] == state_reg.period);
        overflow = (state_reg.count == PTM_CNT_MAX);
        on_rise = on_bit & ~state_reg.on_last;
        pulse_mode = (mode == PTM_MODE_PWM) && (func == PTM_FN_PULSE);
        // Capture source pick by source bit
        cap_rise = state_reg.ctrl1[PTM_CSRC_BIT] ? trig_rise : cin_rise;
        cap_fall = state_reg.ctrl1[PTM_CSRC_BIT] ? trig_fall : cin_fall;
        case (func)
            2'b00: cap_hit = cap_rise;
            2'b01: cap_hit = cap_fall;
            2'b10: cap_hit = cap_rise | cap_fall;
            default: cap_hit = 1'b0;
        endcase
        bus_req = wb_cyc_i & wb_stb_i & ~state_reg.ack & ~state_reg.err;
        bus_wr = bus_req & wb_we_i & wb_sel_i[0];
        reg_ofs = {wb_adr_i[4:2], 2'b00};
        flag_page = (wb_adr_i[5] == PTM_FLAG_PAGE[0]);
    end

    ////////////////////////////////////////////////////////////////////////
    // Counter, flags, pin and register file
    always_comb
    begin
        state_next = state_reg;
        state_next.ack = 1'b0;
        state_next.err = 1'b0;
        state_next.on_last = on_bit;

        // Write one clears; events further down set again, so a set wins
        if (bus_wr && flag_page && reg_ofs == PTM_FLAG_OFS)
        begin
            if (wb_dat_i[PTM_FLAG_A_BIT])
                state_next.flag_a = 1'b0;
            if (wb_dat_i[PTM_FLAG_P_BIT])
                state_next.flag_p = 1'b0;
        end

        // Counter behaviour per mode
        if (on_rise)
        begin
            state_next.count = PTM_CNT_RST;
            if (mode == PTM_MODE_CMP)
                state_next.pin_raw = oc_bit;
        end
        else if (on_bit && !paused)
        begin
            case (mode)
                PTM_MODE_CMP, PTM_MODE_TMR:
                begin
                    if (state_reg.ctrl1[PTM_CCLR_BIT])
                    begin
                        // Zero A value runs to overflow with no A flag
                        if (state_reg.cmp_a == PTM_CNT_RST)
                            state_next.count = count_inc;
                        else if (match_a)
                            state_next.count = PTM_CNT_RST;
                        else
                            state_next.count = count_inc;
                    end
                    else if (state_reg.period == PTM_CNT_RST)
                        state_next.count = count_inc;
                    else if (match_p)
                        state_next.count = PTM_CNT_RST;
                    else
                        state_next.count = count_inc;
                    if (match_a && state_reg.cmp_a != PTM_CNT_RST)
                    begin
                        state_next.flag_a = 1'b1;
                        if (mode == PTM_MODE_CMP)
                        begin
                            case (func)
                                PTM_FN_LOW: state_next.pin_raw = 1'b0;
                                PTM_FN_HIGH: state_next.pin_raw = 1'b1;
                                PTM_FN_TOG:
                                    state_next.pin_raw = ~state_reg.pin_raw;
                                default:
                                    state_next.pin_raw = state_reg.pin_raw;
                            endcase
                        end
                    end
                    if (!state_reg.ctrl1[PTM_CCLR_BIT] &&
                        (match_p || (state_reg.period == PTM_CNT_RST &&
                        overflow)))
                        state_next.flag_p = 1'b1;
                end
                PTM_MODE_PWM:
                begin
                    if (pulse_mode)
                    begin
                        state_next.count = count_inc;
                        if (match_a)
                        begin
                            state_next.flag_a = 1'b1;
                            state_next.ctrl0[PTM_ON_BIT] = 1'b0;
                        end
                    end
                    else
                    begin
                        // Zero period wraps naturally after 1024 ticks
                        if (match_p)
                            state_next.count = PTM_CNT_RST;
                        else
                            state_next.count = count_inc;
                        if (match_a)
                            state_next.flag_a = 1'b1;
                        if (match_p)
                            state_next.flag_p = 1'b1;
                    end
                end
                PTM_MODE_CAP:
                begin
                    if (match_p)
                    begin
                        state_next.count = PTM_CNT_RST;
                        state_next.flag_p = 1'b1;
                    end
                    else
                        state_next.count = count_inc;
                end
                default: state_next.count = state_reg.count;
            endcase
        end

        // Capture copies the count into the A value
        if (mode == PTM_MODE_CAP && on_bit && cap_hit)
        begin
            state_next.cmp_a = state_reg.count;
            state_next.flag_a = 1'b1;
        end

        // External trigger starts a single pulse
        if (pulse_mode && !on_bit && trig_rise)
            state_next.ctrl0[PTM_ON_BIT] = 1'b1;

        // Output waveform before polarity
        state_next.pin_out = state_reg.pin_raw;
        state_next.pin_oe = 1'b0;
        case (mode)
            PTM_MODE_CMP: state_next.pin_oe = 1'b1;
            PTM_MODE_PWM:
            begin
                state_next.pin_oe = 1'b1;
                case (func)
                    PTM_FN_NONE: state_next.pin_out = ~oc_bit;
                    PTM_FN_LOW: state_next.pin_out = oc_bit;
                    PTM_FN_PWM:
                        // Full on when duty reaches the period
                        state_next.pin_out = (state_reg.count <
                            state_reg.cmp_a || (state_reg.period !=
                            PTM_CNT_RST && state_reg.cmp_a >=
                            state_reg.period)) ? oc_bit : ~oc_bit;
                    default:
                        state_next.pin_out = on_bit ? oc_bit : ~oc_bit;
                endcase
            end
            default: state_next.pin_oe = 1'b0;
        endcase
        if (pol_bit && state_next.pin_oe)
            state_next.pin_out = ~state_next.pin_out;

        // Wishbone access, one wait-free ack or err per request
        state_next.rdata = 32'h0000_0000;
        if (bus_req)
        begin
            state_next.ack = 1'b1;
            if (flag_page)
            begin
                if (reg_ofs == PTM_FLAG_OFS)
                begin
                    state_next.rdata[PTM_FLAG_A_BIT] = state_reg.flag_a;
                    state_next.rdata[PTM_FLAG_P_BIT] = state_reg.flag_p;
                end
                else
                begin
                    state_next.ack = 1'b0;
                    state_next.err = 1'b1;
                end
            end
            else
            begin
                case (reg_ofs)
                    PTM_CTRL0_OFS: state_next.rdata[7:0] = state_reg.ctrl0;
                    PTM_CTRL1_OFS: state_next.rdata[7:0] = state_reg.ctrl1;
                    PTM_CNT_LO_OFS: state_next.rdata[7:0] =
                        state_reg.count[7:0];
                    PTM_CNT_HI_OFS: state_next.rdata[1:0] =
                        state_reg.count[9:8];
                    PTM_CMPA_LO_OFS: state_next.rdata[7:0] =
                        state_reg.cmp_a[7:0];
                    PTM_CMPA_HI_OFS: state_next.rdata[1:0] =
                        state_reg.cmp_a[9:8];
                    PTM_PER_LO_OFS: state_next.rdata[7:0] =
                        state_reg.period[7:0];
                    default: state_next.rdata[1:0] = state_reg.period[9:8];
                endcase
                if (bus_wr)
                begin
                    case (reg_ofs)
                        PTM_CTRL0_OFS: state_next.ctrl0 =
                            {wb_dat_i[7:3], 3'b000};
                        PTM_CTRL1_OFS: state_next.ctrl1 = wb_dat_i[7:0];
                        PTM_CMPA_LO_OFS: state_next.cmp_a[7:0] = wb_dat_i[7:0];
                        PTM_CMPA_HI_OFS: state_next.cmp_a[9:8] = wb_dat_i[1:0];
                        PTM_PER_LO_OFS: state_next.period[7:0] =
                            wb_dat_i[7:0];
                        PTM_PER_HI_OFS: state_next.period[9:8] =
                            wb_dat_i[1:0];
                        default: state_next.period = state_next.period;
                    endcase
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register with synchronous reset
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    // Outputs straight from flip-flops
    assign wb_dat_o = state_reg.rdata;
    assign wb_ack_o = state_reg.ack;
    assign wb_err_o = state_reg.err;
    assign timer_output_pin = state_reg.pin_out;
    assign timer_output_oe = state_reg.pin_oe;
    assign compare_a_flag = state_reg.flag_a;
    assign compare_p_flag = state_reg.flag_p;

endmodule

// [ptm_timer_properties.sv]
// Purpose: Port-level checks for the periodic timer
// Assumes: Classic Wishbone master, config known only from bus writes
// Notes: Config shadow lags the design, so an age guard skips settling
`timescale 1ns/100ps
module ptm_timer_properties
    import ptm_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    // Pins and flags
    input wire logic external_trigger_pin,
    input wire logic capture_input_pin,
    input wire logic timer_output_pin,
    input wire logic timer_output_oe,
    input wire logic compare_a_flag,
    input wire logic compare_p_flag
);
    typedef struct packed
    {
        logic [7:0] ctl;
        logic on;
        logic [3:0] age;
    } ptm_shadow_type;
    ptm_shadow_type sh_reg;
    ptm_shadow_type sh_next;
    logic req;
    logic wr;
    logic clr;
    logic cfg_ok;
    logic [1:0] mode;
    logic [1:0] func;
    assign req = wb_cyc_i && wb_stb_i;
    assign wr = wb_ack_o && wb_we_i && wb_sel_i[0];
    assign clr = req && wb_we_i && wb_sel_i[0] && wb_adr_i == 6'h20;
    assign mode = sh_reg.ctl[7:6];
    assign func = sh_reg.ctl[5:4];
    assign cfg_ok = sh_reg.age >= 4'h3;
    // Shadow of control writes; age counts cycles since the last one
    always_comb
    begin
        sh_next = sh_reg;
        if (wr && wb_adr_i == 6'h04)
        begin
            sh_next.ctl = wb_dat_i[7:0];
            sh_next.age = 4'h0;
        end
        else if (wr && wb_adr_i == 6'h00)
        begin
            sh_next.on = wb_dat_i[3];
            sh_next.age = 4'h0;
        end
        else if (sh_reg.age != 4'hF)
            sh_next.age = sh_reg.age + 4'h1;
    end
    // Shadow register
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            sh_reg <= '0;
        else
            sh_reg <= sh_next;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held past one cycle");
    a_ack_follows: assert property (req && !wb_ack_o && !wb_err_o
        |=> wb_ack_o || wb_err_o) else $error("request not answered");
    a_answer_once: assert property (!(wb_ack_o && wb_err_o))
        else $error("ack and err together");
    a_err_unmapped: assert property (req && !wb_ack_o && !wb_err_o
        && wb_adr_i[5] && wb_adr_i[4:2] != 3'h0 |=> wb_err_o)
        else $error("unmapped flag address not refused");
    a_hi_byte_zero: assert property (wb_ack_o && !wb_we_i
        && wb_adr_i[2] && !wb_adr_i[5] && wb_adr_i[4:3] != 2'h0
        |-> wb_dat_o[7:2] == 6'h00)
        else $error("high byte upper bits not zero");
    a_flag_clear_cause: assert property ($fell(compare_a_flag)
        |-> $past(clr) || $past(clr, 2)) else $error("flag lost");
    a_tmr_no_drive: assert property (cfg_ok && mode == 2'b11
        |-> !timer_output_oe) else $error("pin driven in timer mode");
    a_cap_edge_flag: assert property (cfg_ok && mode == 2'b01
        && sh_reg.on && func == 2'b00 && !sh_reg.ctl[1] && !compare_a_flag
        && $rose(capture_input_pin) |-> ##[1:4] compare_a_flag)
        else $error("capture edge raised no flag");
    a_cap_off_quiet: assert property (cfg_ok && mode == 2'b01
        && func == 2'b11 |-> !$rose(compare_a_flag))
        else $error("capture while disabled");
    a_cclr_no_p: assert property (cfg_ok && mode[0] == mode[1]
        && sh_reg.ctl[0] |-> !$rose(compare_p_flag))
        else $error("period flag with clear on A");
    // Main scenarios
    c_err: cover property (wb_err_o);
    c_p_flag: cover property ($rose(compare_p_flag));
    c_pin_fall: cover property ($fell(timer_output_pin));
endmodule

bind ptm_timer ptm_timer_properties i_props
(
    .sys_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o,
    .external_trigger_pin, .capture_input_pin, .timer_output_pin,
    .timer_output_oe, .compare_a_flag, .compare_p_flag
);

// [tb_top.sv]
// Purpose: Self-checking bench for the periodic timer
// Assumes: Ack answers one cycle after the taking edge
// Notes: Pulse and capture checks allow a cycle of pin latency
`timescale 1ns/100ps
module tb_top
    import ptm_pkg::*;
;
    typedef struct
    {
        logic [7:0] c;
        logic [9:0] p;
        logic [9:0] a;
        int w;
        int h;
        logic fa;
    } ptm_row_type;
    logic sys_clk = 1'b0;
    logic rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o;
    logic [5:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic trig, cap, pin, oe, fa, fp;
    logic [7:0] v, x;
    int fails = 0;
    int checks = 0;
    int hi;
    ptm_row_type rows [8] = '{
        '{8'hA8, 10'h008, 10'h003, 80, 30, 1'b1},
        '{8'hAC, 10'h008, 10'h003, 80, 50, 1'b1},
        '{8'hA8, 10'h008, 10'h008, 80, 80, 1'b1},
        '{8'hA8, 10'h008, 10'h009, 80, 80, 1'b0},
        '{8'hA8, 10'h000, 10'h100, 1024, 256, 1'b1},
        '{8'h88, 10'h008, 10'h003, 80, 0, 1'b1},
        '{8'hA0, 10'h008, 10'h003, 80, 50, 1'b1},
        '{8'hA9, 10'h008, 10'h003, 80, 30, 1'b1}};
    always #4 sys_clk = ~sys_clk;
    ptm_timer i_dut (.sys_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o,
        .external_trigger_pin(trig), .capture_input_pin(cap),
        .timer_output_pin(pin), .timer_output_oe(oe),
        .compare_a_flag(fa), .compare_p_flag(fp));
    ptm_pin_model i_pins (.sys_clk, .external_trigger_pin(trig),
        .capture_input_pin(cap));
    ////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic hang(input string s);
        fails++;
        $display("BAD %0t no answer from %s", $time, s);
        end_of_test();
    endtask
    // One classic cycle; held until ack or err is sampled high
    task automatic wb(input logic [5:0] a, input logic we,
        input logic [7:0] d, output logic [7:0] r, output logic e);
        int n = 0;
        wb_adr_i <= a;
        wb_we_i <= we;
        wb_dat_i <= {24'h000000, d};
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 50);
        if (n == 50)
            hang("bus");
        r = wb_dat_o[7:0];
        e = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [7:0] r;
        logic e;
        wb(a, 1'b1, d, r, e);
    endtask
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        logic e;
        wb(a, 1'b0, 8'h00, d, e);
    endtask
    // Stop, load both values and the mode, clear flags, maybe start
    task automatic setup(input logic [7:0] c, input logic [9:0] p,
        input logic [9:0] a, input logic on);
        wr(6'h00, 8'h00);
        wr(6'h10, a[7:0]);
        wr(6'h14, {6'h00, a[9:8]});
        wr(6'h18, p[7:0]);
        wr(6'h1C, {6'h00, p[9:8]});
        wr(6'h04, c);
        wr(6'h20, 8'h03);
        if (on)
            wr(6'h00, 8'h08);
    endtask
    task automatic wait_flag(input logic use_p);
        int n = 0;
        while ((use_p ? fp : fa) !== 1'b1 && n < 3000)
        begin
            @(posedge sys_clk);
            n++;
        end
        if (n == 3000)
            hang("flag");
    endtask
    task automatic count_hi(input int w, output int h);
        h = 0;
        repeat (w)
        begin
            @(posedge sys_clk);
            h += int'(pin === 1'b1);
        end
    endtask
    ////////////////////////////////////////////////////////////////////
    initial
    begin
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
        wb_adr_i <= 6'h00;
        wb_sel_i <= 4'h1;
        wb_dat_i <= 32'h00000000;
        rst_n <= 1'b0;
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        foreach (rows[i])
        begin
            setup(rows[i].c, rows[i].p, rows[i].a, 1'b1);
            repeat (16) @(posedge sys_clk);
            count_hi(rows[i].w, hi);
            check(32'(hi), 32'(rows[i].h));
            check(32'(fa), 32'(rows[i].fa));
            if (rows[i].p != 10'h000)
                check(32'(fp), 32'h00000001);
            $display("pwm row %0d done", i);
        end
        for (int f = 0; f < 4; f++)
        begin
            setup({2'b00, 2'(f), f != 2, 3'h0}, 10'h032, 10'h014, 1'b1);
            @(negedge sys_clk);
            check(32'(pin), 32'(f != 2));
            check(32'(oe), 32'h00000001);
            wait_flag(1'b0);
            repeat (2) @(posedge sys_clk);
            check(32'(pin), 32'(f == 0 || f == 2));
            wait_flag(1'b1);
            check(32'(pin), 32'(f == 0 || f == 2));
            check(32'(fa), 32'h00000001);
        end
        $display("compare output done");
        setup(8'h01, 10'h003, 10'h005, 1'b1);
        wait_flag(1'b0);
        repeat (30) @(posedge sys_clk);
        rd(6'h08, v);
        check(32'(fp), 32'h00000000);
        check(32'(v < 8'h05), 32'h00000001);
        setup(8'h01, 10'h000, 10'h000, 1'b1);
        repeat (1100) @(posedge sys_clk);
        check(32'(fa), 32'h00000000);
        setup(8'hC0, 10'h00A, 10'h004, 1'b1);
        wait_flag(1'b1);
        check(32'(fa), 32'h00000001);
        check(32'(oe), 32'h00000000);
        $display("clear modes done");
        setup(8'hB8, 10'h000, 10'h014, 1'b0);
        fork
            i_pins.pulse(1'b1, 2);
            count_hi(60, hi);
        join
        check(32'(hi >= 18 && hi <= 22), 32'h00000001);
        check(32'(fa), 32'h00000001);
        rd(6'h00, v);
        check(32'(v[3]), 32'h00000000);
        rd(6'h08, v);
        repeat (5) @(posedge sys_clk);
        rd(6'h08, x);
        check(32'(x), 32'(v));
        wr(6'h00, 8'h08);
        rd(6'h08, v);
        check(32'(v < 8'h0A), 32'h00000001);
        wr(6'h00, 8'h00);
        repeat (2) @(posedge sys_clk);
        check(32'(pin), 32'h00000000);
        $display("single pulse done");
        for (int f = 0; f < 4; f++)
        begin
            setup({2'b01, 2'(f), 2'h0, f[0], 1'b0}, 10'h000, 10'h000, 1'b1);
            repeat (20) @(posedge sys_clk);
            i_pins.pulse(f[0], 4);
            repeat (6) @(posedge sys_clk);
            rd(6'h10, v);
            check(32'(fa), 32'(f != 3));
            check(32'(f == 3 ? v == 8'h00 : v >= 8'h0F && v <= 8'h2D),
                32'h00000001);
        end
        $display("capture done");
        wb(6'h24, 1'b0, 8'h00, v, x[0]);
        check(32'(x[0]), 32'h00000001);
        rst_n <= 1'b0;
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        check(32'({fa, fp, pin, oe}), 32'h00000000);
        for (int k = 0; k < 9; k++)
        begin
            rd(6'(k * 4), v);
            check(32'(v), 32'h00000000);
        end
        wr(6'h14, 8'hFF);
        rd(6'h14, v);
        check(32'(v), 32'h00000003);
        wr(6'h1C, 8'hFE);
        rd(6'h1C, v);
        check(32'(v), 32'h00000002);
        wr(6'h18, 8'hA5);
        rd(6'h18, v);
        check(32'(v), 32'h000000A5);
        $display("registers done");
        end_of_test();
    end
endmodule
